// ---- pkg/oodt_pkg.sv ----
// Purpose: shared constants for the on/off delay timer block
// Assumes: one 40 MHz clock, period 25 ns
// Notes: unit codes select the tick that one delay count is worth
`default_nettype none
package oodt_pkg;
  localparam int CLK_PERIOD_NS = 25;
  localparam int MS_NS = 1000000;
  // cycles per millisecond, rounded down (exact at 40 MHz)
  localparam int CYC_PER_MS = MS_NS / CLK_PERIOD_NS;
  localparam int MS_PER_S = 1000;
  localparam int S_PER_MIN = 60;
  localparam int MIN_PER_H = 60;
  localparam int DELAY_W = 16;
  localparam logic [15:0] DELAY_MAX = 16'hFFFF;
  localparam logic [15:0] DELAY_RESET = 16'h0000;
  localparam logic [1:0] UNIT_RESET = 2'h0;
  typedef enum logic [1:0] {UNIT_MS, UNIT_S, UNIT_MIN, UNIT_H} oodt_unit_t;
  typedef enum {ST_IDLE, ST_TIMING, ST_DONE} oodt_state_t;
endpackage
`default_nettype wire

// ---- logic/oodt_delay_core.sv ----
// Purpose: one delay timer; on-delay or off-delay by parameter
// Assumes: trig already synchronised; tick pulses once per unit
// Notes: a zero delay passes the active edge on the next tick
`default_nettype none
module oodt_delay_core #(
  parameter bit OFF_MODE = 1'b0
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  input wire logic clkEn,
  // timing
  input wire logic trig,
  input wire logic tick,
  input wire logic [15:0] delay,
  // result
  output logic timerOutput
);
  oodt_pkg::oodt_state_t state;
  logic [15:0] elapsed;
  // level that starts the countdown: high for on-delay, low for off-delay
  logic armed;
  assign armed = OFF_MODE ? !trig : trig;
  // the selected tick that finishes the countdown
  logic expire;
  assign expire = state == oodt_pkg::ST_TIMING && armed && tick && elapsed >= delay;

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      state <= oodt_pkg::ST_IDLE;
      elapsed <= 16'h0000;
    end
    else if (clkEn)
    begin
      case (state)
        oodt_pkg::ST_IDLE:
        begin
          elapsed <= 16'h0000;
          if (armed)
            state <= oodt_pkg::ST_TIMING;
        end
        oodt_pkg::ST_TIMING:
        begin
          // a break in the level abandons the partial delay
          if (!armed)
            state <= oodt_pkg::ST_IDLE;
          else if (tick)
          begin
            if (elapsed >= delay)
              state <= oodt_pkg::ST_DONE;
            else
              elapsed <= elapsed + 16'h0001;
          end
        end
        oodt_pkg::ST_DONE:
          if (!armed)
            state <= oodt_pkg::ST_IDLE;
        default:
          state <= oodt_pkg::ST_IDLE;
      endcase
    end
  end

  // on output leaves the rest level only when the delay has run out; off output returns to it then
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      timerOutput <= 1'b0;
    else if (clkEn)
    begin
      // off output only falls from high, so a low trigger out of reset stays at rest
      if (OFF_MODE)
        timerOutput <= trig || (timerOutput && !expire);
      else
        timerOutput <= trig && (state == oodt_pkg::ST_DONE || expire);
    end
  end
endmodule
`default_nettype wire

// ---- logic/oodt_timers.sv ----
// Purpose: on-delay and off-delay timers sharing one unit tick chain
// Assumes: trigger inputs come from outside the clock domain
// Notes: tick phase is free running, so each delay has up to one unit of
//   start jitter; traded for one shared prescaler instead of one per timer
// Function
// - on output rises after full high delay
// - on output low at once when trigger low
// - off output falls after full low delay
// - off output high at once when trigger high
// - delay is unsigned 0 to 65535
// - connected delay input overrides stored value
// - off timer scales delay by selected unit
// - delay value writable into stored configuration
`default_nettype none
module oodt_timers #(
  parameter int CYC_PER_MS = oodt_pkg::CYC_PER_MS
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  input wire logic clkEn,
  // triggers
  input wire logic onTrig,
  input wire logic offTrig,
  // on-delay configuration
  input wire logic onDelayWrite,
  input wire logic [15:0] onDelayWriteValue,
  input wire logic onDelayConnected,
  input wire logic [15:0] onDelayIn,
  input wire logic [1:0] onUnit,
  // off-delay configuration
  input wire logic offDelayWrite,
  input wire logic [15:0] offDelayWriteValue,
  input wire logic offDelayConnected,
  input wire logic [15:0] offDelayIn,
  input wire logic [1:0] offUnit,
  // outputs
  output logic on_delay_out,
  output logic off_delay_out
);
  logic [1:0] onSync;
  logic [1:0] offSync;
  logic [15:0] onStored;
  logic [15:0] offStored;
  logic [31:0] prescale;
  logic [9:0] msCount;
  logic [5:0] secCount;
  logic [5:0] minCount;
  logic msTick;
  logic secTick;
  logic minTick;
  logic hourTick;
  logic onTick;
  logic offTick;
  logic [15:0] onDelay;
  logic [15:0] offDelay;

  // triggers cross in through two flops; only the second stage is read
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      onSync <= 2'h0;
    end
    else if (clkEn)
    begin
      onSync <= {onSync[0], onTrig};
    end
  end

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      offSync <= 2'h0;
    end
    else if (clkEn)
    begin
      offSync <= {offSync[0], offTrig};
    end
  end

  // stored delays; 16-bit ports keep any value inside 0..65535
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      onStored <= oodt_pkg::DELAY_RESET;
    end
    else if (clkEn)
    begin
      if (onDelayWrite)
        onStored <= onDelayWriteValue;
    end
  end

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      offStored <= oodt_pkg::DELAY_RESET;
    end
    else if (clkEn)
    begin
      if (offDelayWrite)
        offStored <= offDelayWriteValue;
    end
  end

  // a connected source always wins over the stored value
  always_comb
  begin
    if (onDelayConnected)
      onDelay = onDelayIn;
    else
      onDelay = onStored;
  end

  always_comb
  begin
    if (offDelayConnected)
      offDelay = offDelayIn;
    else
      offDelay = offStored;
  end

  // shared unit tick chain: ms, s, min, h
  assign msTick = prescale == 32'(CYC_PER_MS - 1);
  assign secTick = msTick && msCount == 10'(oodt_pkg::MS_PER_S - 1);
  assign minTick = secTick && secCount == 6'(oodt_pkg::S_PER_MIN - 1);
  assign hourTick = minTick && minCount == 6'(oodt_pkg::MIN_PER_H - 1);

  // prescale wraps on its own count only, never on a trigger edge
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      prescale <= 32'h0000_0000;
    end
    else if (clkEn)
    begin
      if (msTick)
        prescale <= 32'h0000_0000;
      else
        prescale <= prescale + 32'h0000_0001;
    end
  end

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      msCount <= 10'h000;
    end
    else if (clkEn && msTick)
    begin
      if (secTick)
        msCount <= 10'h000;
      else
        msCount <= msCount + 10'h001;
    end
  end

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      secCount <= 6'h00;
    end
    else if (clkEn && secTick)
    begin
      if (minTick)
        secCount <= 6'h00;
      else
        secCount <= secCount + 6'h01;
    end
  end

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      minCount <= 6'h00;
    end
    else if (clkEn && minTick)
    begin
      if (hourTick)
        minCount <= 6'h00;
      else
        minCount <= minCount + 6'h01;
    end
  end

  // each timer picks its own unit from the common chain
  always_comb
  begin
    case (onUnit)
      oodt_pkg::UNIT_MS: onTick = msTick;
      oodt_pkg::UNIT_S: onTick = secTick;
      oodt_pkg::UNIT_MIN: onTick = minTick;
      default: onTick = hourTick;
    endcase
  end

  always_comb
  begin
    case (offUnit)
      oodt_pkg::UNIT_MS: offTick = msTick;
      oodt_pkg::UNIT_S: offTick = secTick;
      oodt_pkg::UNIT_MIN: offTick = minTick;
      default: offTick = hourTick;
    endcase
  end

  oodt_delay_core #(
    .OFF_MODE(1'b0)
  ) onTimer (
    .mclk(mclk),
    .reset(reset),
    .clkEn(clkEn),
    .trig(onSync[1]),
    .tick(onTick),
    .delay(onDelay),
    .timerOutput(on_delay_out)
  );

  oodt_delay_core #(
    .OFF_MODE(1'b1)
  ) offTimer (
    .mclk(mclk),
    .reset(reset),
    .clkEn(clkEn),
    .trig(offSync[1]),
    .tick(offTick),
    .delay(offDelay),
    .timerOutput(off_delay_out)
  );
endmodule
`default_nettype wire

// ---- tb/oodt_timers_asserts.sv ----
// Purpose: port checks for oodt_timers
// Assumes: outputs move 3 edges after a trigger edge
// Notes: clkEn low pauses all checks
`default_nettype none
module oodt_timers_asserts (
  // clock
  input wire logic mclk,
  input wire logic reset,
  input wire logic clkEn,
  // in
  input wire logic onTrig,
  input wire logic offTrig,
  // out
  input wire logic on_delay_out,
  input wire logic off_delay_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (reset || !clkEn);
  on_low_a: assert property (!onTrig [*3] |=> !on_delay_out) else $error("on high");
  off_high_a: assert property (offTrig [*3] |=> off_delay_out) else $error("off low");
  on_cause_a: assert property (on_delay_out |-> $past(onTrig, 3)) else $error("on early");
  off_drop_a: assert property ($fell(off_delay_out) |-> !$past(offTrig, 3))
    else $error("off fell");
  off_rise_a: assert property ($rose(off_delay_out) |-> $past(offTrig, 3))
    else $error("off rose");
  on_hold_a: assert property (onTrig [*2] ##1 (onTrig && on_delay_out) |=> on_delay_out)
    else $error("on dropped");
  off_hold_a: assert property (
    !offTrig [*2] ##1 (!offTrig && !off_delay_out) |=> !off_delay_out)
    else $error("off rose early");
  reset_low_a: assert property (
    $fell(reset) |-> (!on_delay_out && !off_delay_out) [*2])
    else $error("out after reset");
  cover property ($rose(on_delay_out));
  cover property ($fell(off_delay_out));
  cover property (onTrig ##1 !onTrig);
endmodule
bind oodt_timers oodt_timers_asserts i_chk (.mclk, .reset, .clkEn, .onTrig, .offTrig,
  .on_delay_out, .off_delay_out);
`default_nettype wire

// ---- tb/oodt_trig_src.sv ----
// Purpose: upstream logic driving both triggers
// Assumes: commands change at the falling edge
// Notes: skew keeps triggers off the mclk edges
`default_nettype none
module oodt_trig_src (
  // commands
  input wire logic wantOn,
  input wire logic wantOff,
  // triggers
  output logic onTrig,
  output logic offTrig
);
  timeunit 1ns;
  timeprecision 1ps;
  assign #3 onTrig = wantOn;
  assign #3 offTrig = wantOff;
endmodule
`default_nettype wire

// ---- tb/oodt_timers_tb_top.sv ----
// Purpose: bench for oodt_timers
// Assumes: CYC_PER_MS cut to 4
// Notes: free tick phase, so delays are checked as ranges
`default_nettype none
module oodt_timers_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CYC = 4;
  logic mclk = '0, reset = '1, wantOn = '0, wantOff = '0, wr = '0, conn = '1, en = '1;
  logic onTrig, offTrig, onOut, offOut;
  logic [15:0] dIn = '0;
  logic [1:0] unit = '0;
  logic [31:0] rng = 32'hf7df_06e8;
  int failures = 0, checked = 0, n;
  always #12.5 mclk = ~mclk;
  oodt_trig_src i_oodt_trig_src (.wantOn, .wantOff, .onTrig, .offTrig);
  oodt_timers #(.CYC_PER_MS(CYC)) i_oodt_timers (.mclk, .reset, .clkEn(en), .onTrig,
    .offTrig, .onDelayWrite(wr), .onDelayWriteValue(dIn), .onDelayConnected(conn),
    .onDelayIn(dIn), .onUnit(unit), .offDelayWrite(wr), .offDelayWriteValue(dIn),
    .offDelayConnected(conn), .offDelayIn(dIn), .offUnit(unit), .on_delay_out(onOut),
    .off_delay_out(offOut));
  function automatic logic [31:0] xs(logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction
  // earliest or latest cycle count for a delay of d ticks of t cycles
  function automatic int win(int d, int t, bit late);
    return late ? (d + 1) * t + 6 : d * t + 2;
  endfunction
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED %s exp %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic waitFor(bit off, logic lvl, int lim);
    n = 0;
    while ((off ? offOut : onOut) !== lvl)
    begin
      @(negedge mclk);
      n++;
      if (n > lim)
      begin
        failures++;
        wrap_up();
      end
    end
  endtask
  task automatic run(bit off, int d, int t);
    {wantOff, wantOn} = 2'h1 << off;
    waitFor(off, 1, off ? 6 : win(d, t, 1));
    chk("rise", off ? n <= 5 : n >= win(d, t, 0), 1);
    repeat (CYC + 8) @(negedge mclk);
    chk("hold", off ? offOut : onOut, 1);
    {wantOff, wantOn} = 2'h0;
    waitFor(off, 0, off ? win(d, t, 1) : 6);
    chk("fall", off ? n >= win(d, t, 0) : n <= 5, 1);
  endtask
  initial
  begin
    repeat (8) @(negedge mclk);
    reset = '0;
    chk("rstOut", {onOut, offOut}, 0);
    // a low off trigger out of reset must leave the off output at rest
    @(negedge mclk);
    chk("rstRest", {onOut, offOut}, 0);
    for (int i = 0; i < 8; i++)
    begin
      rng = xs(rng);
      dIn = i < 2 ? 16'h0 : 16'(rng % 4);
      run(i[0], dIn, CYC);
    end
    // stored value must win once the input is disconnected
    conn = '0;
    dIn = 16'h3;
    wr = '1;
    @(negedge mclk);
    wr = '0;
    dIn = 16'h50;
    run(0, 3, CYC);
    run(1, 3, CYC);
    conn = '1;
    dIn = 16'h5;
    {wantOff, wantOn} = 2'h3;
    repeat (6) @(negedge mclk);
    {wantOff, wantOn} = 2'h0;
    repeat (2) @(negedge mclk);
    wantOff = '1;
    repeat (30) @(negedge mclk);
    chk("pulses", {onOut, offOut}, 1);
    wantOff = '0;
    waitFor(1, 0, win(5, CYC, 1));
    dIn = 16'h0;
    // clock enable low freezes synchroniser, ticks and timer alike
    en = '0;
    wantOn = '1;
    repeat (40) @(negedge mclk);
    chk("frozen", onOut, 0);
    en = '1;
    waitFor(0, 1, win(0, CYC, 1));
    wantOn = '0;
    waitFor(0, 0, 6);
    unit = 2'h1;
    run(0, 0, 1000 * CYC);
    run(1, 0, 1000 * CYC);
    for (int u = 2; u < 4; u++)
    begin
      unit = u[1:0];
      wantOn = '1;
      repeat (5000) @(negedge mclk);
      chk("longUnit", onOut, 0);
      wantOn = '0;
      repeat (6) @(negedge mclk);
    end
    wrap_up();
  end
endmodule
`default_nettype wire
